// File: rtl/tcu_top.sv
// Overview of operation
// - each qualifying pin event copies the 16-bit source count into the capture pair
// - mode selects falling, rising, every 4th or every 16th rising edge
// - each capture sets the irq flag; only software clears it
// - a newer capture overwrites the older value, no overrun flag
// - edge detector watches the pin level, including levels the device drives
// - mode change may set the flag; software masks and clears it
// - prescaler held clear while unit off or not in capture mode
// - every reset clears the prescaler counter
// - switching between capture prescales does not clear the prescaler
// - two identical independent units with own control, capture, flag, enable
// - second unit's pin may be routed to an alternate pin
// - capture keeps working in sleep when the source count still advances
`timescale 1ns/1ps
`default_nettype none
module tcu_top
  import tcu_pkg::*;
(
  // wishbone slave
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [5:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // capture source count
  input wire logic [15:0] SRC_COUNT_I,
  // capture pins, level seen at the pad
  input wire logic UNIT_ONE_PIN_I,
  input wire logic UNIT_TWO_PIN_I,
  input wire logic UNIT_TWO_ALT_PIN_I,
  // interrupt
  output logic IRQ_O
);

  typedef struct packed {
    logic [TCU_UNITS-1:0][1:0] sync;
    logic [TCU_UNITS-1:0] last;
    logic [TCU_UNITS-1:0][3:0] mode;
    logic [TCU_UNITS-1:0][3:0] presc;
    logic [TCU_UNITS-1:0][15:0] cap;
    logic [1:0] flag;
    logic [1:0] ien;
    logic alt;
    logic ack;
    logic [31:0] dat;
  } tcu_state_t;

  tcu_state_t s_q;
  tcu_state_t s_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_capture(input logic [3:0] m);
    return (m == TCU_MODE_FALL) || (m == TCU_MODE_RISE) ||
           (m == TCU_MODE_RISE4) || (m == TCU_MODE_RISE16);
  endfunction

  function automatic logic [31:0] wmask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  logic [TCU_UNITS-1:0] pin_raw;
  logic [TCU_UNITS-1:0] cap_ev;
  logic req;
  logic wr;
  logic [31:0] wm;

  // pad level already includes any level the device drives itself
  assign pin_raw[0] = UNIT_ONE_PIN_I;
  assign pin_raw[1] = s_q.alt ? UNIT_TWO_ALT_PIN_I : UNIT_TWO_PIN_I;
  assign req = CYC_I && STB_I && !s_q.ack;
  assign wr = req && WE_I;
  assign wm = wmask(SEL_I);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic rise;
    logic fall;
    logic [3:0] pn;
    rise = 1'b0;
    fall = 1'b0;
    pn = 4'h0;
    s_d = s_q;
    cap_ev = '0;
    s_d.ack = req;
    for (int u = 0; u < TCU_UNITS; u++) begin
      s_d.sync[u] = {s_q.sync[u][0], pin_raw[u]};
      s_d.last[u] = s_q.sync[u][1];
      rise = s_q.sync[u][1] && !s_q.last[u];
      fall = !s_q.sync[u][1] && s_q.last[u];
      pn = s_q.presc[u] + 4'h1;
      if (!is_capture(s_q.mode[u])) begin
        s_d.presc[u] = 4'h0;
      end else begin
        unique case (s_q.mode[u])
          TCU_MODE_FALL: cap_ev[u] = fall;
          TCU_MODE_RISE: cap_ev[u] = rise;
          TCU_MODE_RISE4: begin
            if (rise) begin
              s_d.presc[u] = pn;
              cap_ev[u] = (s_q.presc[u][1:0] == TCU_PRESC_4[1:0]);
            end
          end
          TCU_MODE_RISE16: begin
            if (rise) begin
              s_d.presc[u] = pn;
              cap_ev[u] = (s_q.presc[u] == TCU_PRESC_16);
            end
          end
          default: cap_ev[u] = 1'b0;
        endcase
      end
      if (cap_ev[u]) begin
        s_d.cap[u] = SRC_COUNT_I;
      end
    end
    s_d.dat = 32'h0000_0000;
    if (req && !WE_I) begin
      unique case (ADR_I)
        TCU_CTRL0_OFS: s_d.dat = {28'h0000000, s_q.mode[0]};
        TCU_CAPL0_OFS: s_d.dat = {24'h000000, s_q.cap[0][7:0]};
        TCU_CAPH0_OFS: s_d.dat = {24'h000000, s_q.cap[0][15:8]};
        TCU_CTRL1_OFS: s_d.dat = {28'h0000000, s_q.mode[1]};
        TCU_CAPL1_OFS: s_d.dat = {24'h000000, s_q.cap[1][7:0]};
        TCU_CAPH1_OFS: s_d.dat = {24'h000000, s_q.cap[1][15:8]};
        TCU_FLAG_OFS: s_d.dat = {30'h00000000, s_q.flag};
        TCU_IEN_OFS: s_d.dat = {30'h00000000, s_q.ien};
        TCU_ALTP_OFS: s_d.dat = {31'h00000000, s_q.alt};
        default: s_d.dat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (ADR_I)
        TCU_CTRL0_OFS: if (SEL_I[0]) s_d.mode[0] = DAT_I[3:0];
        TCU_CTRL1_OFS: if (SEL_I[0]) s_d.mode[1] = DAT_I[3:0];
        TCU_CAPL0_OFS: if (SEL_I[0]) s_d.cap[0][7:0] = DAT_I[7:0];
        TCU_CAPH0_OFS: if (SEL_I[0]) s_d.cap[0][15:8] = DAT_I[7:0];
        TCU_CAPL1_OFS: if (SEL_I[0]) s_d.cap[1][7:0] = DAT_I[7:0];
        TCU_CAPH1_OFS: if (SEL_I[0]) s_d.cap[1][15:8] = DAT_I[7:0];
        TCU_FLAG_OFS: s_d.flag = s_q.flag & ~(DAT_I[1:0] & wm[1:0]);
        TCU_IEN_OFS: if (SEL_I[0]) s_d.ien = DAT_I[1:0];
        TCU_ALTP_OFS: if (SEL_I[0]) s_d.alt = DAT_I[0];
        default: s_d.flag = s_q.flag;
      endcase
    end
    // set wins over a same-cycle clear
    s_d.flag = s_d.flag | cap_ev;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_q <= '0;
    end else if (CE_I) begin
      s_q <= s_d;
    end
  end

  assign DAT_O = s_q.dat;
  assign ACK_O = s_q.ack;
  assign IRQ_O = |(s_q.flag & s_q.ien);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  // ----------------------------------------------------------------
  // capture path
  // ----------------------------------------------------------------
  a_capture_loads_count: assert property (CE_I && cap_ev[0] && !wr |=>
    s_q.cap[0] == $past(SRC_COUNT_I)) else $error("capture value not loaded");

  a_unit_two_load: assert property (CE_I && cap_ev[1] && !wr |=>
    s_q.cap[1] == $past(SRC_COUNT_I)) else $error("unit two value not loaded");

  a_no_event_off: assert property (!is_capture(s_q.mode[0]) |->
    !cap_ev[0]) else $error("event while unit off");

  a_rise4_fourth: assert property (s_q.mode[0] == TCU_MODE_RISE4 &&
    s_q.sync[0][1] && !s_q.last[0] && s_q.presc[0][1:0] == TCU_PRESC_4[1:0] |->
    cap_ev[0]) else $error("fourth rising edge missed");

  a_rise4_others: assert property (s_q.mode[0] == TCU_MODE_RISE4 &&
    s_q.presc[0][1:0] != TCU_PRESC_4[1:0] |-> !cap_ev[0])
    else $error("early prescaled capture");

  a_rise16_only: assert property (s_q.mode[0] == TCU_MODE_RISE16 &&
    s_q.presc[0] != TCU_PRESC_16 |-> !cap_ev[0])
    else $error("early sixteenth capture");

  a_presc_kept_switch: assert property (CE_I && s_q.mode[0] == TCU_MODE_RISE4 &&
    wr && ADR_I == TCU_CTRL0_OFS && SEL_I[0] && DAT_I[3:0] == TCU_MODE_RISE16 &&
    !(s_q.sync[0][1] && !s_q.last[0]) |=> s_q.presc[0] == $past(s_q.presc[0]))
    else $error("prescaler cleared on switch");

  // ----------------------------------------------------------------
  // flags and routing
  // ----------------------------------------------------------------
  a_flag_set_capture: assert property (CE_I && cap_ev[1] |=> s_q.flag[1])
    else $error("capture flag not set");
  a_flag_sticky: assert property (s_q.flag[0] && !(wr && ADR_I == TCU_FLAG_OFS) |=>
    s_q.flag[0]) else $error("flag cleared without software");
  a_presc_held_off: assert property (!is_capture(s_q.mode[0]) && CE_I |=>
    s_q.presc[0] == 4'h0) else $error("prescaler not held clear");
  a_rise_mode_event: assert property (s_q.mode[0] == TCU_MODE_RISE &&
    s_q.sync[0][1] && !s_q.last[0] |-> cap_ev[0]) else $error("rising edge missed");
  a_fall_no_event: assert property (s_q.mode[0] == TCU_MODE_FALL &&
    s_q.sync[0][1] |-> !cap_ev[0]) else $error("event on wrong edge");
  a_sync_two_stage: assert property (CE_I ##1 CE_I |->
    s_q.sync[0][1] == $past(UNIT_ONE_PIN_I, 2)) else $error("sync depth wrong");
  a_flag_clear_write: assert property (CE_I && wr && ADR_I == TCU_FLAG_OFS &&
    SEL_I[0] && DAT_I[0] && !cap_ev[0] |=> !s_q.flag[0])
    else $error("flag not cleared by write");

  a_irq_level: assert property (CE_I && cap_ev[1] && s_q.ien[1] |=> IRQ_O)
    else $error("irq missing after enabled capture");

  a_alt_routing: assert property (CE_I && s_q.alt |=>
    s_q.sync[1][0] == $past(UNIT_TWO_ALT_PIN_I)) else $error("alternate pin not used");

  a_main_routing: assert property (CE_I && !s_q.alt |=>
    s_q.sync[1][0] == $past(UNIT_TWO_PIN_I)) else $error("main pin not used");

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  a_ack_single_pulse: assert property (CE_I && ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");

  a_ack_follows_req: assert property (CE_I && CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("request not acknowledged");

  a_dat_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0000_0000)
    else $error("read data outside ack");

  // ----------------------------------------------------------------
  // scenarios reached
  // ----------------------------------------------------------------

  c_capture_one: cover property (cap_ev[0]);
  c_capture_two: cover property (cap_ev[1] && s_q.alt);
  c_sixteenth: cover property (s_q.mode[0] == TCU_MODE_RISE16 && cap_ev[0]);
  c_fall_capture: cover property (s_q.mode[0] == TCU_MODE_FALL && cap_ev[0]);
  c_fourth: cover property (s_q.mode[0] == TCU_MODE_RISE4 && cap_ev[0]);

endmodule
`default_nettype wire

// File: rtl/tcu_pkg.sv
package tcu_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [5:0] TCU_CTRL0_OFS = 6'h00;
  localparam logic [5:0] TCU_CAPL0_OFS = 6'h04;
  localparam logic [5:0] TCU_CAPH0_OFS = 6'h08;
  localparam logic [5:0] TCU_CTRL1_OFS = 6'h0c;
  localparam logic [5:0] TCU_CAPL1_OFS = 6'h10;
  localparam logic [5:0] TCU_CAPH1_OFS = 6'h14;
  localparam logic [5:0] TCU_FLAG_OFS = 6'h18;
  localparam logic [5:0] TCU_IEN_OFS = 6'h1c;
  localparam logic [5:0] TCU_ALTP_OFS = 6'h20;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int TCU_MODE_LSB = 0;
  localparam int TCU_MODE_W = 4;
  localparam logic [3:0] TCU_MODE_RST = 4'h0;
  localparam logic [3:0] TCU_MODE_FALL = 4'h4;
  localparam logic [3:0] TCU_MODE_RISE = 4'h5;
  localparam logic [3:0] TCU_MODE_RISE4 = 4'h6;
  localparam logic [3:0] TCU_MODE_RISE16 = 4'h7;
  localparam logic [3:0] TCU_PRESC_4 = 4'h3;
  localparam logic [3:0] TCU_PRESC_16 = 4'hf;
  localparam logic [15:0] TCU_CAP_RST = 16'h0000;
  localparam logic [1:0] TCU_FLAG_RST = 2'h0;
  localparam logic [1:0] TCU_IEN_RST = 2'h0;
  localparam logic TCU_ALTP_RST = 1'b0;
  localparam int TCU_UNITS = 2;

endpackage

// File: test/tcu_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcu_pin_model (
  // clock
  input wire logic clk_i,
  // pad levels: unit one, unit two, unit two alternate
  output logic [2:0] pins_o
);
  initial pins_o = 3'h0;
  // pins are pure inputs of the unit; one level change, then time for sync and capture
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge clk_i);
    pins_o[idx] <= lvl;
    repeat (6) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: test/timer_capture_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer_capture_unit_bench;
  import tcu_pkg::*;
  logic clk, arst_n, cyc, stb, we, ack, irq;
  logic [5:0] adr;
  logic [31:0] dat_w, dat_r, rd;
  logic [15:0] count;
  logic [2:0] pins;
  int errors, checks_done, n;
  tcu_top DUT (.CLK_I(clk), .ARST_N_I(arst_n), .CE_I(1'b1), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'hf), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack),
    .SRC_COUNT_I(count), .UNIT_ONE_PIN_I(pins[0]), .UNIT_TWO_PIN_I(pins[1]),
    .UNIT_TWO_ALT_PIN_I(pins[2]), .IRQ_O(irq));
  tcu_pin_model PINS (.clk_i(clk), .pins_o(pins));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // bus cycles and checks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20) begin
      errors++;
      $display("MISMATCH %0t no ack", $time);
    end
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask
  task automatic mode(input logic [5:0] a, input logic [3:0] m);
    bus(1'b1, a, {28'h0, m});
  endtask
  task automatic rise(input int idx);
    PINS.set_pin(idx, 1'b1);
    PINS.set_pin(idx, 1'b0);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    {cyc, stb, we, adr, dat_w} = '0;
    count = 16'h1234;
    errors = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk(TCU_CTRL1_OFS, 32'h0);
    chk(6'h24, 32'h0);
    mode(TCU_CTRL0_OFS, TCU_MODE_RISE);
    rise(0);
    chk(TCU_CAPL0_OFS, 32'h34);
    chk(TCU_CAPH0_OFS, 32'h12);
    chk(TCU_FLAG_OFS, 32'h1);
    count <= 16'h5678;
    rise(0);
    chk(TCU_CAPL0_OFS, 32'h78);
    chk(TCU_FLAG_OFS, 32'h1);
    bus(1'b1, TCU_IEN_OFS, 32'h1);
    cmp({31'h0, irq}, 32'h1);
    bus(1'b1, TCU_FLAG_OFS, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    bus(1'b1, TCU_IEN_OFS, 32'h0);
    mode(TCU_CTRL0_OFS, TCU_MODE_FALL);
    bus(1'b1, TCU_FLAG_OFS, 32'h1);
    count <= 16'h9abc;
    PINS.set_pin(0, 1'b1);
    chk(TCU_FLAG_OFS, 32'h0);
    PINS.set_pin(0, 1'b0);
    chk(TCU_CAPH0_OFS, 32'h9a);
    mode(TCU_CTRL0_OFS, TCU_MODE_RISE4);
    rise(0);
    rise(0);
    mode(TCU_CTRL0_OFS, 4'h0);
    mode(TCU_CTRL0_OFS, TCU_MODE_RISE4);
    bus(1'b1, TCU_FLAG_OFS, 32'h1);
    count <= 16'h0f0e;
    repeat (3) rise(0);
    chk(TCU_FLAG_OFS, 32'h0);
    rise(0);
    chk(TCU_CAPL0_OFS, 32'h0e);
    rise(0);
    rise(0);
    mode(TCU_CTRL0_OFS, TCU_MODE_RISE16);
    bus(1'b1, TCU_FLAG_OFS, 32'h1);
    n = 0;
    do begin
      rise(0);
      n++;
      bus(1'b0, TCU_FLAG_OFS, 32'h0);
    end while (rd !== 32'h1 && n < 16);
    cmp(n, 32'h0000000a);
    mode(TCU_CTRL0_OFS, 4'h0);
    mode(TCU_CTRL0_OFS, TCU_MODE_RISE16);
    bus(1'b1, TCU_FLAG_OFS, 32'h1);
    count <= 16'h4321;
    repeat (15) rise(0);
    chk(TCU_FLAG_OFS, 32'h0);
    rise(0);
    chk(TCU_CAPH0_OFS, 32'h43);
    bus(1'b1, TCU_ALTP_OFS, 32'h1);
    mode(TCU_CTRL1_OFS, TCU_MODE_RISE);
    bus(1'b1, TCU_FLAG_OFS, 32'h3);
    count <= 16'hbeef;
    rise(1);
    chk(TCU_FLAG_OFS, 32'h0);
    rise(2);
    chk(TCU_CAPL1_OFS, 32'hef);
    chk(TCU_CAPH1_OFS, 32'hbe);
    chk(TCU_FLAG_OFS, 32'h2);
    give_verdict();
  end
endmodule
`default_nettype wire
